/* logic/dpc_pkg.sv */
// Constants and types shared by the pin control and serial port design
package dpc_pkg;

    localparam int          REG_COUNT     = 16;
    localparam int          ADDR_W        = 4;
    localparam int          DATA_W        = 8;
    localparam logic [7:0]  REG_RESET     = 8'h00;
    localparam logic [3:0]  REG_OSC_ADDR  = 4'h7;
    localparam int          OSC_EN_POS    = 4;
    localparam logic [2:0]  LAST_BIT      = 3'h7;

    // Internal oscillator runs at 2.5 MHz, derived from the 20 MHz clock
    localparam int          CLK_HZ        = 20000000;
    localparam int          OSC_HZ        = 2500000;
    localparam int          OSC_HALF_INT  = CLK_HZ / (2 * OSC_HZ);
    localparam logic [3:0]  OSC_HALF      = 4'(OSC_HALF_INT);

    // Conversion length in conversion clock cycles
    localparam logic [4:0]  CONV_CCLKS    = 5'h0e;

    typedef struct packed {
        logic             rd;
        logic [2:0]       spare;
        logic [ADDR_W-1:0] addr;
    } dpc_cmd_t;

    typedef struct packed {
        logic out;
        logic oe;
    } dpc_drive_t;

    typedef enum logic [1:0] {
        SP_CMD  = 2'b01,
        SP_DATA = 2'b10
    } dpc_port_state_t;

    typedef enum logic [1:0] {
        CV_IDLE = 2'b01,
        CV_BUSY = 2'b10
    } dpc_conv_state_t;

endpackage

/* logic/dpc_sync.sv */
// Two flip-flop synchroniser for levels entering a clock domain
`timescale 1ns/1ps
module dpc_sync
    import dpc_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] async,
    output logic      [W-1:0] synced
);
    logic [W-1:0] stage_ff;

    // First stage feeds only the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage_ff <= '0;
            synced   <= '0;
        end else begin
            stage_ff <= async;
            synced   <= stage_ff;
        end
    end
endmodule // dpc_sync

/* logic/dpc_regmem.sv */
// Internal register store with registered read port
`timescale 1ns/1ps
module dpc_regmem
    import dpc_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              wrEn,
    input  wire logic [ADDR_W-1:0] wrAddr,
    input  wire logic [DATA_W-1:0] wrData,
    input  wire logic [ADDR_W-1:0] rdAddr,
    output logic      [DATA_W-1:0] rdData
);
    logic [DATA_W-1:0] mem_ff [REG_COUNT];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                mem_ff[i] <= REG_RESET;
            end
        end else if (wrEn) begin
            mem_ff[wrAddr] <= wrData;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdData <= REG_RESET;
        end else begin
            rdData <= mem_ff[rdAddr];
        end
    end
endmodule // dpc_regmem

/* logic/dpc_top.sv */
// Pin control, conversion sequencing and serial port of the converter
`timescale 1ns/1ps
module dpc_top
    import dpc_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic sclk,
    input  wire logic edgeSelRise,
    input  wire logic csN,
    input  wire logic dinIn,
    output logic      dinOut,
    output logic      dinOe,
    output logic      dout,
    output logic      doutOe,
    input  wire logic twoWireMode,
    input  wire logic convertTrig,
    output logic      busy,
    input  wire logic oscillator_drive_select,
    input  wire logic conversion_clock_pin_in,
    output logic      conversion_clock_pin_out,
    output logic      conversion_clock_pin_oe
);
    // ---------------- Link domain ----------------
    logic       linkClk;
    logic       linkRst;
    logic [2:0] bitCnt_ff;
    logic [7:0] rxSh_ff;
    logic [7:0] rxHold_ff;
    logic       rxTgl_ff;
    logic [7:0] txSh_ff;
    logic       txAck_ff;
    logic       txTglLink;
    logic       txTgl_ff;
    logic [7:0] txWord_ff;

    // Active edge select
    // Edge select is a strap; changing it mid-frame makes a spurious edge
    assign linkClk = sclk ^ ~edgeSelRise;
    assign linkRst = rst | csN;

    // Toggle sync is kept through deselect so a pending word is not lost
    dpc_sync #(.W(1)) uTxSync (
        .clk    (linkClk),
        .rst    (rst),
        .async  (txTgl_ff),
        .synced (txTglLink)
    );

    always_ff @(posedge linkClk or posedge linkRst) begin
        if (linkRst) begin
            bitCnt_ff <= 3'h0;
            rxSh_ff   <= 8'h00;
        end else begin
            bitCnt_ff <= bitCnt_ff + 3'h1;
            rxSh_ff   <= {rxSh_ff[6:0], dinIn};
        end
    end

    // Completed byte is held stable while its toggle crosses over
    always_ff @(posedge linkClk or posedge rst) begin
        if (rst) begin
            rxHold_ff <= 8'h00;
            rxTgl_ff  <= 1'b0;
        end else if (!csN && bitCnt_ff == LAST_BIT) begin
            rxHold_ff <= {rxSh_ff[6:0], dinIn};
            rxTgl_ff  <= ~rxTgl_ff;
        end
    end

    always_ff @(posedge linkClk or posedge linkRst) begin
        if (linkRst) begin
            txSh_ff <= 8'h00;
        end else if (bitCnt_ff == LAST_BIT) begin
            txSh_ff <= (txTglLink != txAck_ff) ? txWord_ff : 8'h00;
        end else begin
            txSh_ff <= {txSh_ff[6:0], 1'b0};
        end
    end

    // Ack survives deselect, so each handed-over word is sent once only
    always_ff @(posedge linkClk or posedge rst) begin
        if (rst) begin
            txAck_ff <= 1'b0;
        end else if (!csN && bitCnt_ff == LAST_BIT) begin
            txAck_ff <= txTglLink;
        end
    end

    // Output bit is the shifter msb
    assign dout   = txSh_ff[7];
    assign dinOut = txSh_ff[7];

    // ---------------- System domain ----------------
    logic            rxTglSync;
    logic            rxTglSeen_ff;
    logic            csNSync;
    logic            twoWireSync;
    logic            convSync;
    logic            convPrev_ff;
    logic            cclkSync;
    logic            cclkPrev_ff;
    logic            rxEvent;
    dpc_cmd_t        cmd;
    dpc_port_state_t portState_ff;
    dpc_port_state_t nxt_portState;
    logic [ADDR_W-1:0] addr_ff;
    logic            rdPend_ff;
    logic            wrEn;
    logic [DATA_W-1:0] rdData;
    logic            oscEnBit_ff;

    logic            oscSelSync;

    // All pins entering the system domain pass two flops
    dpc_sync #(.W(6)) uInSync (
        .clk    (clk),
        .rst    (rst),
        .async  ({rxTgl_ff, csN, twoWireMode, convertTrig,
                  conversion_clock_pin_in, oscillator_drive_select}),
        .synced ({rxTglSync, csNSync, twoWireSync, convSync, cclkSync, oscSelSync})
    );

    assign rxEvent = rxTglSync != rxTglSeen_ff;
    assign cmd     = dpc_cmd_t'(rxHold_ff);
    assign wrEn    = rxEvent && portState_ff == SP_DATA && !csNSync;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rxTglSeen_ff <= 1'b0;
        end else begin
            rxTglSeen_ff <= rxTglSync;
        end
    end

    // First byte is a command, second the write data
    always_comb begin
        nxt_portState = portState_ff;
        unique case (portState_ff)
            SP_CMD: begin
                if (rxEvent && !cmd.rd) begin
                    nxt_portState = SP_DATA;
                end
            end
            SP_DATA: begin
                if (rxEvent) begin
                    nxt_portState = SP_CMD;
                end
            end
            default: nxt_portState = SP_CMD;
        endcase
        if (csNSync) begin
            nxt_portState = SP_CMD;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            portState_ff <= SP_CMD;
        end else begin
            portState_ff <= nxt_portState;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addr_ff <= '0;
        end else if (rxEvent && portState_ff == SP_CMD) begin
            addr_ff <= cmd.addr;
        end
    end

    dpc_regmem uRegs (
        .clk    (clk),
        .rst    (rst),
        .wrEn   (wrEn),
        .wrAddr (addr_ff),
        .wrData (rxHold_ff),
        .rdAddr (cmd.addr),
        .rdData (rdData)
    );

    // Read data is one cycle behind the address, so the load waits a cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdPend_ff <= 1'b0;
            txWord_ff <= 8'h00;
            txTgl_ff  <= 1'b0;
        end else begin
            rdPend_ff <= rxEvent && portState_ff == SP_CMD && cmd.rd && !csNSync;
            if (rdPend_ff) begin
                txWord_ff <= rdData;
                txTgl_ff  <= ~txTgl_ff;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            oscEnBit_ff <= 1'b0;
        end else if (wrEn && addr_ff == REG_OSC_ADDR) begin
            oscEnBit_ff <= rxHold_ff[OSC_EN_POS];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            doutOe <= 1'b0;
            dinOe  <= 1'b0;
        end else begin
            doutOe <= !csNSync;
            dinOe  <= !csNSync && twoWireSync;
        end
    end

    // ---------------- Conversion clock ----------------
    logic [3:0] oscCnt_ff;
    logic       oscOn;
    dpc_drive_t cclkDrv_ff;

    assign oscOn = oscSelSync | oscEnBit_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            oscCnt_ff  <= 4'h0;
            cclkDrv_ff <= '0;
        end else if (!oscOn) begin
            oscCnt_ff  <= 4'h0;
            cclkDrv_ff <= '0;
        end else begin
            cclkDrv_ff.oe <= 1'b1;
            if (oscCnt_ff == OSC_HALF - 4'h1) begin
                oscCnt_ff      <= 4'h0;
                cclkDrv_ff.out <= ~cclkDrv_ff.out;
            end else begin
                oscCnt_ff <= oscCnt_ff + 4'h1;
            end
        end
    end

    assign conversion_clock_pin_out = cclkDrv_ff.out;
    assign conversion_clock_pin_oe  = cclkDrv_ff.oe;

    // ---------------- Conversion sequencing ----------------
    dpc_conv_state_t convState_ff;
    logic [4:0]      convCnt_ff;
    logic            cclkRise;

    // Clock is sensed at the pin whoever drives it
    assign cclkRise = cclkSync && !cclkPrev_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            convPrev_ff <= 1'b0;
            cclkPrev_ff <= 1'b0;
        end else begin
            convPrev_ff <= convSync;
            cclkPrev_ff <= cclkSync;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            convState_ff <= CV_IDLE;
            convCnt_ff   <= 5'h00;
            busy         <= 1'b0;
        end else begin
            unique case (convState_ff)
                CV_IDLE: begin
                    if (convSync && !convPrev_ff) begin
                        convState_ff <= CV_BUSY;
                        convCnt_ff   <= 5'h00;
                        busy         <= 1'b1;
                    end
                end
                CV_BUSY: begin
                    if (cclkRise) begin
                        if (convCnt_ff == CONV_CCLKS - 5'h01) begin
                            convState_ff <= CV_IDLE;
                            busy         <= 1'b0;
                        end else begin
                            convCnt_ff <= convCnt_ff + 5'h01;
                        end
                    end
                end
                default: begin
                    convState_ff <= CV_IDLE;
                    busy         <= 1'b0;
                end
            endcase
        end
    end
endmodule // dpc_top

/* bench/dpc_top_asserts.sv */
// Checker for the pin control and serial port
`timescale 1ns/1ps
module dpc_top_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic csN,
    input wire logic twoWireMode,
    input wire logic doutOe,
    input wire logic dinOe,
    input wire logic convertTrig,
    input wire logic busy,
    input wire logic oscillator_drive_select,
    input wire logic conversion_clock_pin_in,
    input wire logic conversion_clock_pin_out,
    input wire logic conversion_clock_pin_oe
);
    logic [4:0] riseCnt_ff;
    logic       pinQ_ff;

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // Raw pin rises, one either way versus the design's synced count
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pinQ_ff <= 1'b0;
            riseCnt_ff <= 5'h00;
        end else begin
            pinQ_ff <= conversion_clock_pin_in;
            if (!busy)
                riseCnt_ff <= 5'h00;
            else if (conversion_clock_pin_in && !pinQ_ff)
                riseCnt_ff <= riseCnt_ff + 5'h01;
        end
    end

    sequence s_csIdle;
        csN [*4];
    endsequence
    sequence s_twoSel;
        (!csN && twoWireMode) [*5];
    endsequence

    property p_csLow;
        $fell(csN) |-> ##[1:4] doutOe;
    endproperty
    property p_csHigh;
        s_csIdle |-> !doutOe && !dinOe;
    endproperty
    property p_twoWire;
        s_twoSel |-> dinOe;
    endproperty
    property p_threeWire;
        (!twoWireMode) [*5] |-> !dinOe;
    endproperty
    property p_convStart;
        $rose(convertTrig) && !busy |-> ##[2:4] busy;
    endproperty
    property p_busyCause;
        $rose(busy) |-> $past(convertTrig, 2);
    endproperty
    property p_busyLen;
        $fell(busy) |-> riseCnt_ff inside {[5'h0d:5'h0f]};
    endproperty
    property p_oscOn;
        oscillator_drive_select [*4] |-> conversion_clock_pin_oe;
    endproperty
    property p_oscRun;
        conversion_clock_pin_oe [*8] |->
            conversion_clock_pin_out != $past(conversion_clock_pin_out, 4);
    endproperty

    a_csLow: assert property (p_csLow)
        else $error("data out not driven after select");
    a_csHigh: assert property (p_csHigh)
        else $error("pins driven while deselected");
    a_twoWire: assert property (p_twoWire)
        else $error("data in pin not driven in two-wire mode");
    a_threeWire: assert property (p_threeWire)
        else $error("data in pin driven in three-wire mode");
    a_convStart: assert property (p_convStart)
        else $error("trigger did not start conversion");
    a_busyCause: assert property (p_busyCause)
        else $error("busy without trigger");
    a_busyLen: assert property (p_busyLen)
        else $error("conversion length wrong");
    a_oscOn: assert property (p_oscOn)
        else $error("oscillator not driven on pin");
    a_oscRun: assert property (p_oscRun)
        else $error("oscillator not toggling");
endmodule // dpc_top_asserts

/* bench/dpc_host_model.sv */
// Host serial port model
`timescale 1ns/1ps
module dpc_host_model (
    input  wire logic edgeSelRise,
    input  wire logic dout,
    output logic      sclk,
    output logic      csN,
    output logic      dinIn
);
    initial begin
        sclk = 1'b1;
        csN = 1'b1;
        dinIn = 1'b1;
    end
    task automatic sel(input logic v);
        csN = v;
    endtask
    task automatic frame(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c,
                         output logic [7:0] r);
        logic [23:0] tx;
        tx = {a, b, c};
        sclk = ~edgeSelRise;
        csN = 1'b0;
        #125;
        for (int i = 23; i >= 0; i--) begin
            dinIn = tx[i];
            #62.5;
            r[i % 8] = dout;
            sclk = edgeSelRise;
            #62.5;
            sclk = ~edgeSelRise;
        end
        #125;
        csN = 1'b1;
        // Released line must not keep the last bit
        dinIn = ~dinIn;
        // Deselect long enough for the clock side to see it
        #250;
    endtask
endmodule // dpc_host_model

/* bench/daq_pin_control_serial_port_test.sv */
// Testbench for the pin control and serial port
`timescale 1ns/1ps
module daq_pin_control_serial_port_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic edgeSelRise = 1'b0;
    logic twoWireMode = 1'b0;
    logic convertTrig = 1'b0;
    logic oscSel = 1'b0;
    logic extClk = 1'b0;
    int   fails = 0;
    int   checks = 0;
    wire logic sclk, csN, hostDin, dinOut, dinOe, dout, doutOe, busy, pinOut, pinOe;
    wire logic dinPin = dinOe ? dinOut : hostDin;
    wire logic pinLvl = pinOe ? pinOut : extClk;

    always #25 clk = ~clk;
    always #200 extClk = ~extClk;

    dpc_top uut (.clk(clk), .rst(rst), .sclk(sclk), .edgeSelRise(edgeSelRise),
        .csN(csN), .dinIn(dinPin), .dinOut(dinOut), .dinOe(dinOe), .dout(dout),
        .doutOe(doutOe), .twoWireMode(twoWireMode), .convertTrig(convertTrig),
        .busy(busy), .oscillator_drive_select(oscSel), .conversion_clock_pin_in(pinLvl),
        .conversion_clock_pin_out(pinOut), .conversion_clock_pin_oe(pinOe));
    dpc_host_model host (.edgeSelRise(edgeSelRise), .dout(dout), .sclk(sclk),
        .csN(csN), .dinIn(hostDin));

    task automatic results;
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] r;
        host.frame({4'h0, a}, d, 8'h80, r);
    endtask
    // Read data comes back two bytes after its command
    task automatic rd(input logic [3:0] a, output logic [7:0] r);
        host.frame({4'h8, a}, 8'h80, 8'h80, r);
    endtask

    task automatic t_serial;
        logic [7:0] r;
        rd(4'h3, r);
        chk(r, 8'h00);
        wr(4'h5, 8'ha5);
        wr(4'h6, 8'h3c);
        rd(4'h5, r);
        chk(r, 8'ha5);
        rd(4'h6, r);
        chk(r, 8'h3c);
        $display("t_serial done");
    endtask
    task automatic t_pins;
        host.sel(1'b0);
        @(posedge clk) twoWireMode <= 1'b1;
        cyc(6);
        chk(doutOe, 1'b1);
        chk(dinOe, 1'b1);
        @(posedge clk) twoWireMode <= 1'b0;
        cyc(6);
        chk(dinOe, 1'b0);
        host.sel(1'b1);
        @(posedge clk) twoWireMode <= 1'b1;
        cyc(6);
        chk(doutOe, 1'b0);
        chk(dinOe, 1'b0);
        @(posedge clk) twoWireMode <= 1'b0;
        $display("t_pins done");
    endtask
    task automatic t_conv;
        int n;
        @(posedge clk) convertTrig <= 1'b1;
        cyc(4);
        chk(busy, 1'b1);
        chk(pinOe, 1'b0);
        host.sel(1'b0);
        cyc(20);
        host.sel(1'b1);
        chk(busy, 1'b1);
        n = 24;
        while (busy === 1'b1 && n < 200) begin
            cyc(1);
            n++;
        end
        // 14 pin clocks of 8 cycles, first one 1 to 8 cycles after busy rises
        chk(n >= 108 && n <= 118, 1'b1);
        @(posedge clk) convertTrig <= 1'b0;
        $display("t_conv done");
    endtask
    task automatic t_osc;
        logic prev;
        @(posedge clk) oscSel <= 1'b1;
        cyc(3);
        chk(pinOe, 1'b1);
        prev = pinOut;
        cyc(4);
        chk(pinOut ^ prev, 1'b1);
        @(posedge clk) oscSel <= 1'b0;
        cyc(3);
        chk(pinOe, 1'b0);
        wr(4'h7, 8'h10);
        cyc(3);
        chk(pinOe, 1'b1);
        $display("t_osc done");
    endtask
    task automatic t_edge;
        logic [7:0] r;
        @(posedge clk) rst <= 1'b1;
        edgeSelRise <= 1'b1;
        cyc(2);
        @(posedge clk) rst <= 1'b0;
        cyc(3);
        chk(pinOe, 1'b0);
        rd(4'h7, r);
        chk(r, 8'h00);
        wr(4'h9, 8'hc3);
        rd(4'h9, r);
        chk(r, 8'hc3);
        $display("t_edge done");
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        cyc(3);
        t_serial();
        t_pins();
        t_conv();
        t_osc();
        t_edge();
        results();
    end
    // Whole run needs well under 100 us
    initial begin
        #200000;
        fails++;
        results();
    end
endmodule // daq_pin_control_serial_port_test

bind dpc_top dpc_top_asserts u_chk (.clk(clk), .rst(rst), .csN(csN),
    .twoWireMode(twoWireMode), .doutOe(doutOe), .dinOe(dinOe),
    .convertTrig(convertTrig), .busy(busy),
    .oscillator_drive_select(oscillator_drive_select),
    .conversion_clock_pin_in(conversion_clock_pin_in),
    .conversion_clock_pin_out(conversion_clock_pin_out),
    .conversion_clock_pin_oe(conversion_clock_pin_oe));
